// ===== swmon_map.vh
// Functional notes
// - Mode code sits in top two response bits
// - Role, interrupt, ground, programmable, battery flag layout
// - Role flag mirrors master/slave strap level
// - Interrupt flag is inverse of interrupt pin
// - Interrupt flag is not latched: it takes the inverse of the pin level sampled when chip select falls
// - Switch flag one when closed, zero open
// - Switch states captured when chip select falls
// - Disabled inputs always report zero
// - Disabled inputs lose wetting and sustain current
// - Reset low clears registers, enters sleep
// - Reset release keeps device asleep
// - Only a serial command leaves sleep
// - Sleep response drives zero top bits
// - Reset disables all inputs until host enables
`ifndef SWMON_MAP_VH
`define SWMON_MAP_VH
// Frame geometry
`define SWMON_FRAME_BITS   16
`define SWMON_MODE_HI      15
`define SWMON_MODE_LO      14
`define SWMON_ROLE_BIT     13
`define SWMON_INT_BIT      12
`define SWMON_GND_LO       6
`define SWMON_PRG_LO       2
`define SWMON_BAT_LO       0
`define SWMON_GND_HI       11
`define SWMON_PRG_HI       5
`define SWMON_BAT_HI       1
`define SWMON_SW_HI        11
`define SWMON_SW_LO        0
// Command word fields
`define SWMON_TEST_BIT     15
`define SWMON_CMD_HI       15
`define SWMON_CMD_LO       12
`define SWMON_OPSEL_HI     11
`define SWMON_OPSEL_LO     10
`define SWMON_CFG_HI       11
`define SWMON_CFG_LO       0
// Timing counts
`define SWMON_CNT_FULL     5'h10
// Operating mode codes
`define SWMON_MODE_SLEEP   2'h0
`define SWMON_MODE_NORMAL  2'h1
`define SWMON_MODE_POLL    2'h2
`define SWMON_MODE_POLLWT  2'h3
// Command codes in top four bits
`define SWMON_CMD_RUN      4'h1
`define SWMON_CMD_TRI      4'h3
// Reset values
`define SWMON_ENABLE_RST   12'h000
`define SWMON_MODE_RST     2'h0
`define SWMON_RUN_RST      12'h000
`define SWMON_SHIFT_RST    16'h0000
`define SWMON_CNT_RST      5'h00
`endif

// ===== swmon_sync.v
`timescale 1ns/1ns
// Two-flop synchroniser for asynchronous inputs
module swmon_sync #(
  parameter WIDTH = 1
) (
  input  wire             core_clk_i,
  input  wire             rst_n_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_r;   // First stage, read only by second stage
  reg [WIDTH-1:0] sync_r;   // Second stage

  // Double register the inputs
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= {WIDTH{1'b0}};
      sync_r <= {WIDTH{1'b0}};
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;
endmodule // swmon_sync

// ===== swmon_spi_status.v
`timescale 1ns/1ns
`include "swmon_map.vh"
// Serial status responder of the switch monitor
module swmon_spi_status (
  input  wire        core_clk_i,
  input  wire        rst_n_i,
  input  wire        sclk_i,
  input  wire        cs_n_i,
  input  wire        mosi_i,
  output wire        miso_o,
  output wire        miso_oe_o,
  input  wire        role_strap_i,
  input  wire        int_n_i,
  input  wire [5:0]  ground_switch_state_i,
  input  wire [3:0]  programmable_switch_state_i,
  input  wire [1:0]  battery_switch_state_i,
  output wire [1:0]  operating_select_bits_o,
  output wire [5:0]  ground_input_enable_o,
  output wire [3:0]  programmable_input_enable_o,
  output wire [1:0]  battery_input_enable_o,
  output wire [11:0] current_enable_o,
  output wire [11:0] run_config_o
);
  ////////////////////////////////////////////////////////////////
  // Input synchronisation
  ////////////////////////////////////////////////////////////////
  localparam NSYNC = 17;
  wire [NSYNC-1:0] raw_w;   // Raw pin levels
  wire [NSYNC-1:0] syn_w;   // Synchronised levels

  // Chip select enters inverted so a cleared synchroniser reads deselected
  assign raw_w = {sclk_i, ~cs_n_i, mosi_i, role_strap_i, int_n_i,
                  ground_switch_state_i, programmable_switch_state_i, battery_switch_state_i};

  swmon_sync #(.WIDTH(NSYNC)) u_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (raw_w),
    .sync_o     (syn_w)
  );

  wire        sclk_s = syn_w[16];   // Serial clock
  wire        cs_n_s = ~syn_w[15];  // Chip select, active low
  wire        mosi_s = syn_w[14];   // Command data
  wire        role_s = syn_w[13];   // Master/slave strap
  wire        intn_s = syn_w[12];   // Interrupt pin level
  wire [11:0] sw_s   = syn_w[11:0]; // Switch levels, 1 = closed

  ////////////////////////////////////////////////////////////////
  // Edge detection
  ////////////////////////////////////////////////////////////////
  reg sclk_d_r;   // Previous serial clock
  reg cs_n_d_r;   // Previous chip select

  // Delay copies for edge finding
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_n_d_r <= cs_n_s;
    end
  end

  wire cs_fall = cs_n_d_r & ~cs_n_s;    // Frame start
  wire cs_rise = ~cs_n_d_r & cs_n_s;    // Frame end
  wire sck_rise = ~sclk_d_r & sclk_s & ~cs_n_s;  // Sample edge
  wire sck_fall = sclk_d_r & ~sclk_s & ~cs_n_s;  // Shift edge

  ////////////////////////////////////////////////////////////////
  // Configuration state
  ////////////////////////////////////////////////////////////////
  reg [1:0]  mode_r;      // Operating mode, sleep after reset
  reg [11:0] enable_r;    // Input enables, all off after reset
  reg [11:0] run_r;       // Run command fields
  reg [15:0] rx_r;        // Incoming command shift register
  reg [4:0]  cnt_r;       // Rising serial edges seen in frame
  reg [15:0] tx_r;        // Outgoing response shift register
  reg [2:0]  state_r;     // Frame tracker, one-hot
  reg [2:0]  state_nxt;   // Next value of the frame tracker

  // Frame tracker states, one-hot
  localparam [2:0] ST_IDLE  = 3'h1;   // Deselected, waiting for a frame
  localparam [2:0] ST_SHIFT = 3'h2;   // Selected, bits moving both ways
  localparam [2:0] ST_APPLY = 3'h4;   // Frame closed, command takes effect

  ////////////////////////////////////////////////////////////////
  // Response and command decode
  ////////////////////////////////////////////////////////////////
  // Assemble response snapshot from the mode and sampled pins
  function [15:0] build_resp;
    input [1:0]  mode;   // Current operating mode
    input        role;   // Strap level
    input        intn;   // Interrupt pin level
    input [11:0] sw;     // Switch levels, 1 = closed
    input [11:0] en;     // Input enables
    begin
      build_resp = `SWMON_SHIFT_RST;
      build_resp[`SWMON_MODE_HI:`SWMON_MODE_LO] = mode;
      if (mode != `SWMON_MODE_SLEEP) begin
        build_resp[`SWMON_ROLE_BIT] = role;
        build_resp[`SWMON_INT_BIT]  = ~intn;
        build_resp[`SWMON_SW_HI:`SWMON_SW_LO] = sw & en;
      end
    end
  endfunction

  // True when a frame carries the given command code
  // A set test bit refuses the frame whatever follows
  function cmd_match;
    input [15:0] frame;   // Received command word
    input [3:0]  code;    // Command code to look for
    begin
      cmd_match = ~frame[`SWMON_TEST_BIT] &&
                  (frame[`SWMON_CMD_HI:`SWMON_CMD_LO] == code);
    end
  endfunction

  wire frame_full = (cnt_r == `SWMON_CNT_FULL);                   // Sixteen bits in
  wire apply_w    = (state_r == ST_APPLY);                        // One-cycle command strobe
  wire run_hit    = apply_w & cmd_match(rx_r, `SWMON_CMD_RUN);
  wire tri_hit    = apply_w & cmd_match(rx_r, `SWMON_CMD_TRI);    // Tri-state command

  ////////////////////////////////////////////////////////////////
  // Frame tracker
  ////////////////////////////////////////////////////////////////
  // Next state: a frame ends in apply only when complete
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (cs_fall)
          state_nxt = ST_SHIFT;     // Chip select seen low
      end
      ST_SHIFT: begin
        if (cs_rise) begin
          if (frame_full)
            state_nxt = ST_APPLY;   // Whole frame, act on it
          else
            state_nxt = ST_IDLE;    // Short frame is refused
        end
      end
      ST_APPLY: begin
        if (cs_fall)
          state_nxt = ST_SHIFT;     // Back-to-back frame
        else
          state_nxt = ST_IDLE;      // Strobe lasts one cycle
      end
      default: begin
        state_nxt = ST_IDLE;        // Recover from an illegal code
      end
    endcase
  end

  // Frame tracker register
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Shift registers
  ////////////////////////////////////////////////////////////////
  // Command shifter and bit counter, sampled on serial rise
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_r  <= `SWMON_SHIFT_RST;
      cnt_r <= `SWMON_CNT_RST;
    end else if (cs_fall) begin
      cnt_r <= `SWMON_CNT_RST;                 // New frame counts from zero
    end else if (sck_rise) begin
      rx_r <= {rx_r[14:0], mosi_s};            // Last sixteen bits are kept
      if (!frame_full)
        cnt_r <= cnt_r + 5'h01;                // Saturates on long frames
    end
  end

  // Response shifter: load at frame start, shift on serial fall
  // Loading at the chip-select edge freezes the switch picture
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_r <= `SWMON_SHIFT_RST;
    end else if (cs_fall) begin
      tx_r <= build_resp(mode_r, role_s, intn_s, sw_s, enable_r);
    end else if (sck_fall) begin
      tx_r <= {tx_r[14:0], 1'h0};
    end
  end

  ////////////////////////////////////////////////////////////////
  // Command effects
  ////////////////////////////////////////////////////////////////
  // Mode and run fields; only a run command moves them
  // Sleep is left only here, never by itself after reset
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= `SWMON_MODE_RST;
      run_r  <= `SWMON_RUN_RST;
    end else if (run_hit) begin
      mode_r <= rx_r[`SWMON_OPSEL_HI:`SWMON_OPSEL_LO];
      run_r  <= rx_r[`SWMON_CFG_HI:`SWMON_CFG_LO];
    end
  end

  // Input enables; only the tri-state command writes them
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_r <= `SWMON_ENABLE_RST;
    end else if (tri_hit) begin
      enable_r <= rx_r[`SWMON_CFG_HI:`SWMON_CFG_LO];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////
  assign miso_o    = tx_r[`SWMON_FRAME_BITS-1];
  assign miso_oe_o = ~cs_n_s;                     // Drive only while selected
  assign operating_select_bits_o     = mode_r;
  assign ground_input_enable_o       = enable_r[`SWMON_GND_HI:`SWMON_GND_LO];
  assign programmable_input_enable_o = enable_r[`SWMON_PRG_HI:`SWMON_PRG_LO];
  assign battery_input_enable_o      = enable_r[`SWMON_BAT_HI:`SWMON_BAT_LO];
  assign current_enable_o            = enable_r;
  assign run_config_o                = run_r;
endmodule // swmon_spi_status

// ===== swmon_chk.sv
`timescale 1ns/1ns
// Port-level checks of the status responder
module swmon_chk (
  input wire        core_clk_i,
  input wire        rst_n_i,
  input wire        cs_n_i,
  input wire        miso_o,
  input wire        miso_oe_o,
  input wire [1:0]  operating_select_bits_o,
  input wire [5:0]  ground_input_enable_o,
  input wire [3:0]  programmable_input_enable_o,
  input wire [1:0]  battery_input_enable_o,
  input wire [11:0] current_enable_o
);
  // All twelve enables in response order
  wire [11:0] en = {ground_input_enable_o, programmable_input_enable_o, battery_input_enable_o};
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_rst_sleep: assert property ($rose(rst_n_i) |-> operating_select_bits_o == 2'h0)
    else $error("mode not sleep after reset");
  a_rst_en_off: assert property ($rose(rst_n_i) |-> en == 12'h000)
    else $error("enables set after reset");
  a_oe_idle: assert property (cs_n_i [*4] |-> !miso_oe_o)
    else $error("output driven while deselected");
  a_oe_frame: assert property (!cs_n_i [*4] |-> miso_oe_o)
    else $error("output not driven in frame");
  a_cur_tracks: assert property ($stable(en) [*2] |-> current_enable_o == en)
    else $error("currents differ from enables");
  a_mode_hold: assert property ($changed(operating_select_bits_o) |-> cs_n_i)
    else $error("mode changed inside frame");
  a_en_hold: assert property ($changed(en) |-> cs_n_i)
    else $error("enables changed inside frame");
  a_first_bit: assert property ($fell(cs_n_i) |-> ##6 miso_o == $past(operating_select_bits_o[1], 6))
    else $error("first bit is not mode msb");
  c_frame: cover property ($fell(cs_n_i));
  c_poll_wt: cover property (operating_select_bits_o == 2'h3);
  c_cur_on: cover property (current_enable_o != 12'h000);
endmodule // swmon_chk
bind swmon_spi_status swmon_chk u_chk (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
  .miso_o(miso_o), .miso_oe_o(miso_oe_o), .operating_select_bits_o(operating_select_bits_o),
  .ground_input_enable_o(ground_input_enable_o), .programmable_input_enable_o(programmable_input_enable_o),
  .battery_input_enable_o(battery_input_enable_o), .current_enable_o(current_enable_o));

// ===== swmon_host.sv
`timescale 1ns/1ns
// Host serial master, mode 0, 80 ns link clock
module swmon_host (
  input wire  core_clk_i,
  input wire  miso_i,
  output reg  sclk_o,
  output reg  cs_n_o,
  output reg  mosi_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Half a link period
  task automatic hp;
    repeat (4) @(posedge core_clk_i);
    #1;
  endtask
  // One 16-bit exchange, response sampled on each rising edge
  task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
    integer i;
    @(posedge core_clk_i);
    #1 cs_n_o = 1'b0;
    hp;
    hp;
    for (i = 15; i >= 0; i--) begin
      mosi_o = cmd[i];
      hp;
      sclk_o = 1'b1;
      rsp[i] = miso_i;
      hp;
      sclk_o = 1'b0;
    end
    // Released data line shows the inverse of its last bit
    mosi_o = ~mosi_o;
    hp;
    cs_n_o = 1'b1;
    hp;
    hp;
  endtask
endmodule // swmon_host

// ===== swmon_spi_status_tb.sv
`timescale 1ns/1ns
module swmon_spi_status_tb;
  reg         core_clk_i = 0, rst_n_i = 0, role = 0, int_n = 1;
  reg  [11:0] sw = 12'h000;
  reg  [15:0] rsp;
  wire        sclk, cs_n, mosi, miso;
  wire [1:0]  mode, ben;
  wire [5:0]  gen;
  wire [3:0]  pen;
  wire [11:0] cur, cfg;
  integer     failures = 0, checks = 0, cyc = 0;
  swmon_spi_status dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(), .role_strap_i(role), .int_n_i(int_n), .ground_switch_state_i(sw[11:6]),
    .programmable_switch_state_i(sw[5:2]), .battery_switch_state_i(sw[1:0]), .operating_select_bits_o(mode),
    .ground_input_enable_o(gen), .programmable_input_enable_o(pen), .battery_input_enable_o(ben),
    .current_enable_o(cur), .run_config_o(cfg));
  swmon_host u_host (.core_clk_i(core_clk_i), .miso_i(miso), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
  initial forever #5 core_clk_i = ~core_clk_i;
  task chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checks++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_sleep;
    u_host.xfer(16'h0000, rsp);
    chk("sleep top", 16'h0000, {14'h0000, rsp[15:14]});
    chk("sleep mode", 16'h0000, {14'h0000, mode});
    chk("enables", 16'h0000, {4'h0, gen, pen, ben});
    $display("test sleep done");
  endtask
  task t_modes;
    integer m;
    for (m = 3; m >= 1; m--) begin
      role = m[0];
      int_n = m[1];
      u_host.xfer({4'h1, m[1:0], 10'h000}, rsp);
      u_host.xfer(16'h0000, rsp);
      chk("mode", {14'h0000, m[1:0]}, {14'h0000, rsp[15:14]});
      chk("role", {15'h0000, m[0]}, {15'h0000, rsp[13]});
      if (m != 2) chk("int", {15'h0000, ~m[1]}, {15'h0000, rsp[12]});
    end
    u_host.xfer(16'h9800, rsp);
    chk("refused", 16'h4001, {cfg, 2'h0, mode});
    $display("test modes done");
  endtask
  task t_flags;
    u_host.xfer(16'h3A5C, rsp);
    chk("currents", 16'h0A5C, {4'h0, cur});
    sw = 12'hFFF;
    fork
      u_host.xfer(16'h0000, rsp);
      begin
        repeat (12) @(posedge core_clk_i);
        #1 sw = 12'h000;
      end
    join
    chk("closed", 16'h7A5C, rsp);
    u_host.xfer(16'h0000, rsp);
    chk("open", 16'h7000, rsp);
    $display("test flags done");
  endtask
  task t_reset;
    rst_n_i = 0;
    repeat (3) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    repeat (3) @(posedge core_clk_i);
    #1;
    chk("rst mode", 16'h0000, {14'h0000, mode});
    chk("rst enables", 16'h0000, {4'h0, gen, pen, ben});
    chk("rst currents", 16'h0000, {4'h0, cur});
    chk("rst run", 16'h0000, {4'h0, cfg});
    sw = 12'hFFF;
    u_host.xfer(16'h0000, rsp);
    chk("rst top", 16'h0000, {14'h0000, rsp[15:14]});
    u_host.xfer(16'h1400, rsp);
    u_host.xfer(16'h0000, rsp);
    chk("wake flags", 16'h7000, rsp);
    $display("test reset done");
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge core_clk_i);
    #1 rst_n_i = 1;
    repeat (3) @(posedge core_clk_i);
    t_sleep;
    t_modes;
    t_flags;
    t_reset;
    end_of_test;
  end
endmodule // swmon_spi_status_tb
